// *** verilog/sarc_pkg.sv ***
// constants and types shared by the sar conversion control block
// assumes a 100 MHz system clock and one converter per instance
package sarc_pkg;
   localparam int SARC_RES_BITS = 12;
   localparam int SARC_SYS_CLK_HZ = 100_000_000;
   localparam int SARC_CONV_CLK_MAX_HZ = 18_000_000;
   localparam int SARC_CONV_CLK_MIN_HZ = 1_000_000;
   // fastest legal conversion clock: least divider, rounded up
   localparam int SARC_CONV_DIV = (SARC_SYS_CLK_HZ + SARC_CONV_CLK_MAX_HZ - 1) / SARC_CONV_CLK_MAX_HZ;
   localparam int SARC_CONV_DIV_MAX = SARC_SYS_CLK_HZ / SARC_CONV_CLK_MIN_HZ;
   localparam int SARC_DIV_W = 7;
   localparam int SARC_CONV_STEPS = 18;
   localparam int SARC_SAMPLE_STEPS = 5;
   localparam int SARC_STEP_W = 5;
   localparam logic [SARC_STEP_W-1:0] SARC_LAST_STEP = 5'h11;
   localparam logic [SARC_STEP_W-1:0] SARC_MSB_STEP = 5'h05;
   localparam logic [SARC_STEP_W-1:0] SARC_PRE_MSB_STEP = 5'h04;
   localparam logic [SARC_RES_BITS-1:0] SARC_MSB_MASK = 12'h800;
   localparam int SARC_CLK_PERIOD_NS = 10;
   localparam int SARC_READY_TIME_NS = 10_000;
   localparam int SARC_READY_CYC = (SARC_READY_TIME_NS + SARC_CLK_PERIOD_NS - 1) / SARC_CLK_PERIOD_NS;
   localparam int SARC_WAIT_W = 11;
   localparam int SARC_FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      SARC_ST_OFF = 2'b00,
      SARC_ST_WAIT = 2'b01,
      SARC_ST_IDLE = 2'b11,
      SARC_ST_CONV = 2'b10
   } sarc_state_e;
endpackage

// *** verilog/sarc_conv_ctrl.sv ***
// conversion control of a 12-bit successive-approximation converter and its result fifo
// assumes the analog side settles the comparator within one conversion clock period
// and that the reader of the fifo is on the system clock
//
// How it works
// - each conversion yields one 12-bit result, at most 1 Msps, with single-ended or differential input.
// - result bits are decided one at a time against the dac, msb first and lsb last.
// - the conversion clock is eighteen times the sample rate and lies between 1 MHz and 18 MHz.
// - a conversion starts on the software start bit or on the hardware frame-start input.
// - after power-up or wake no conversion starts until 10 us have passed; starts in that time are dropped.
// - a finished conversion sets a status flag and raises frame-end until the result is read.
// - frame-end is fit to drive an interrupt or a dma request.
// - the single-conversion select picks continuous conversion or one conversion per start.
// - continuous results leave by dma, one request per sample, with no cpu help.
`timescale 1ns/1ns

// ----------------------------------------------------------------
// result fifo
// ----------------------------------------------------------------
module sarc_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out,
   output logic [$clog2(DEPTH):0] level_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic wr_en, rd_en;

   always_comb begin
      in_ready_out = (wr_q - rd_q) != (AW+1)'(DEPTH);
      out_valid_out = wr_q != rd_q;
      wr_en = in_valid_in && in_ready_out;
      rd_en = out_ready_in && out_valid_out;
      wr_d = wr_en ? wr_q + 1'b1 : wr_q;
      rd_d = rd_en ? rd_q + 1'b1 : rd_q;
      level_out = wr_q - rd_q;
      out_data_out = mem_q[rd_q[AW-1:0]];
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
      if (wr_en) begin
         mem_q[wr_q[AW-1:0]] <= in_data_in;
      end
   end
endmodule

// ----------------------------------------------------------------
// conversion control
// ----------------------------------------------------------------
module sarc_conv_ctrl import sarc_pkg::*; #(
   parameter int CONV_DIV = SARC_CONV_DIV,
   parameter int FIFO_DEPTH = SARC_FIFO_DEPTH
) (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic pwr_on_in,
   input wire logic start_in,
   input wire logic frame_start_in,
   input wire logic single_conversion_select_in,
   input wire logic diff_sel_in,
   input wire logic comp_in,
   input wire logic rd_ready_in,
   output logic [SARC_RES_BITS-1:0] dac_code_out,
   output logic sample_out,
   output logic diff_mode_out,
   output logic ready_out,
   output logic busy_out,
   output logic done_flag_out,
   output logic frame_end_out,
   output logic [SARC_RES_BITS-1:0] result_out
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   localparam logic [SARC_DIV_W-1:0] DIV_LAST = SARC_DIV_W'(CONV_DIV - 1);
   localparam logic [SARC_WAIT_W-1:0] WAIT_LAST = SARC_WAIT_W'(SARC_READY_CYC - 1);
   localparam logic [LW-1:0] ROOM_TWO = LW'(FIFO_DEPTH - 2);

   sarc_state_e state_q, state_d;
   logic [SARC_STEP_W-1:0] step_q, step_d;
   logic [SARC_DIV_W-1:0] div_q, div_d;
   logic [SARC_WAIT_W-1:0] wait_q, wait_d;
   logic [SARC_RES_BITS-1:0] sar_q, sar_d, dac_q, dac_d, mask;
   logic diff_q, diff_d, done_q, done_d;
   logic sof_meta_q, sof_sync_q, sof_prev_q, comp_meta_q, comp_sync_q;
   logic tick, sof_rise, start_evt, push, fifo_in_ready, rd_fire;
   logic [LW-1:0] fifo_level;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         sof_meta_q <= 1'b0;
         sof_sync_q <= 1'b0;
         sof_prev_q <= 1'b0;
         comp_meta_q <= 1'b0;
         comp_sync_q <= 1'b0;
      end else begin
         sof_meta_q <= frame_start_in;
         sof_sync_q <= sof_meta_q;
         sof_prev_q <= sof_sync_q;
         comp_meta_q <= comp_in;
         comp_sync_q <= comp_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      tick = div_q == DIV_LAST;
      sof_rise = sof_sync_q && !sof_prev_q;
      // continuous mode needs no start; frame-start may stay unconnected
      start_evt = start_in || sof_rise || !single_conversion_select_in;
      mask = dac_q & ~sar_q;
      state_d = state_q;
      step_d = step_q;
      div_d = tick ? '0 : div_q + 1'b1;
      wait_d = wait_q;
      sar_d = sar_q;
      dac_d = dac_q;
      diff_d = diff_q;
      push = 1'b0;
      case (state_q)
         SARC_ST_OFF: begin
            wait_d = '0;
            if (pwr_on_in) begin
               state_d = SARC_ST_WAIT;
            end
         end
         SARC_ST_WAIT: begin
            // starts are dropped, not queued, until the front end is ready
            if (wait_q == WAIT_LAST) begin
               state_d = SARC_ST_IDLE;
            end else begin
               wait_d = wait_q + 1'b1;
            end
         end
         SARC_ST_IDLE: begin
            if (start_evt && fifo_in_ready) begin
               state_d = SARC_ST_CONV;
               step_d = '0;
               div_d = '0;
               sar_d = '0;
               dac_d = '0;
               diff_d = diff_sel_in;
            end
         end
         SARC_ST_CONV: begin
            // start requests are not looked at here
            if (tick) begin
               step_d = step_q + 1'b1;
               if (step_q == SARC_PRE_MSB_STEP) begin
                  dac_d = SARC_MSB_MASK;
               end else if (mask != '0) begin
                  sar_d = comp_sync_q ? dac_q : sar_q;
                  dac_d = sar_d | (mask >> 1);
               end
               if (step_q == SARC_LAST_STEP) begin
                  push = 1'b1;
                  step_d = '0;
                  sar_d = '0;
                  dac_d = '0;
                  // keep running only while the fifo can take the next result too
                  if (single_conversion_select_in || fifo_level > ROOM_TWO) begin
                     state_d = SARC_ST_IDLE;
                  end
               end
            end
         end
         default: state_d = SARC_ST_OFF;
      endcase
      if (!pwr_on_in) begin
         state_d = SARC_ST_OFF;
      end
      rd_fire = rd_ready_in && frame_end_out;
      done_d = push || (done_q && !rd_fire);
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         state_q <= SARC_ST_OFF;
         step_q <= '0;
         div_q <= '0;
         wait_q <= '0;
         sar_q <= '0;
         dac_q <= '0;
         diff_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
         div_q <= div_d;
         wait_q <= wait_d;
         sar_q <= sar_d;
         dac_q <= dac_d;
         diff_q <= diff_d;
         done_q <= done_d;
      end
   end

   assign dac_code_out = dac_q;
   assign diff_mode_out = diff_q;
   assign ready_out = state_q == SARC_ST_IDLE || state_q == SARC_ST_CONV;
   assign busy_out = state_q == SARC_ST_CONV;
   assign sample_out = busy_out && step_q < SARC_MSB_STEP;
   assign done_flag_out = done_q;

   // frame-end is the fifo's valid: it stays up until every result is read
   sarc_fifo #(
      .WIDTH(SARC_RES_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .in_valid_in(push),
      .in_ready_out(fifo_in_ready),
      .in_data_in(sar_q),
      .out_valid_out(frame_end_out),
      .out_ready_in(rd_ready_in),
      .out_data_out(result_out),
      .level_out(fifo_level)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   localparam int CONV_CYC = SARC_CONV_STEPS * CONV_DIV;
   localparam int CONV_SPAN = SARC_CONV_STEPS * CONV_DIV - 1;
   logic [SARC_DIV_W-1:0] gap_q;
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         gap_q <= '0;
      end else begin
         gap_q <= tick || (state_q == SARC_ST_IDLE && state_d == SARC_ST_CONV) ? '0 : gap_q + 1'b1;
      end
   end

   sequence s_conv_begin;
      state_q == SARC_ST_IDLE ##1 state_q == SARC_ST_CONV;
   endsequence
   sequence s_result_out;
      push ##1 frame_end_out && done_flag_out;
   endsequence

   tick_spacing_a: assert property (tick && busy_out && $past(busy_out) |-> gap_q == DIV_LAST)
      else $error("conversion clock period wrong");
   clk_range_a: assert property (CONV_DIV >= SARC_CONV_DIV && CONV_DIV <= SARC_CONV_DIV_MAX)
      else $error("conversion clock outside legal range");
   ready_delay_a: assert property ($rose(state_q == SARC_ST_WAIT) |-> !busy_out [*8])
      else $error("conversion started during power-up wait");
   ready_time_a: assert property ($rose(ready_out) |-> $past(wait_q) == WAIT_LAST)
      else $error("ready before the wait elapsed");
   // power-down legally aborts a conversion, so timing checks stand down with it
   conv_length_a: assert property (disable iff (!rstn_in || !pwr_on_in) s_conv_begin |-> ##[CONV_SPAN:CONV_SPAN] push)
      else $error("conversion not eighteen clocks long");
   cont_rate_a: assert property (disable iff (!rstn_in || !pwr_on_in)
      push && busy_out && state_d == SARC_ST_CONV |-> ##[CONV_CYC:CONV_CYC] push)
      else $error("continuous result rate wrong");
   done_set_a: assert property (push |-> s_result_out)
      else $error("completion not flagged");
   frame_hold_a: assert property (frame_end_out && !rd_ready_in |=> frame_end_out)
      else $error("frame-end dropped before read");
   msb_first_a: assert property (busy_out && step_q == SARC_MSB_STEP |-> dac_code_out == SARC_MSB_MASK)
      else $error("msb trial not first");
   single_stop_a: assert property (push && single_conversion_select_in && pwr_on_in |=> state_q == SARC_ST_IDLE)
      else $error("single mode kept converting");
   no_restart_a: assert property (busy_out && step_q != SARC_LAST_STEP && pwr_on_in |=> busy_out && step_q >= $past(step_q))
      else $error("start restarted a conversion");
endmodule

// *** sim/sarc_reader.sv ***
// reader model: the cpu or dma side taking results from the fifo head
// assumes the bench samples each read on the rising edge
`timescale 1ns/1ns
module sarc_reader (
   input wire logic clk_sys_in,
   input wire logic frame_end_in,
   input wire logic stall_in,
   output logic rd_ready_out
);
   initial rd_ready_out = 1'b0;
   // frame end is the dma request; one word taken each clock while it is up unless stalled
   always @(negedge clk_sys_in) begin
      rd_ready_out <= frame_end_in && !stall_in;
   end
endmodule

// *** sim/sar_adc_conversion_control_bench.sv ***
// self-checking bench for the sar conversion control and its result fifo
// assumes sarc_reader on the far side; the comparator is modelled here
`timescale 1ns/1ns
module sar_adc_conversion_control_bench;
   import sarc_pkg::*;
   localparam int DIV = 6;
   localparam int CONV = 18 * DIV;
   logic clk_sys_in = 1'b0, rstn_in = 1'b0, pwr_on_in = 1'b0, start_in = 1'b0;
   logic frame_start_in = 1'b0, single_sel = 1'b1, diff_sel = 1'b0, comp_in = 1'b0;
   logic rd_ready, stall = 1'b0, sample, diff_mode, ready, busy, done_flag, frame_end;
   logic [SARC_RES_BITS-1:0] dac_code, result, target = '0;
   logic [SARC_RES_BITS-1:0] got[$];
   logic [SARC_RES_BITS-1:0] corner[4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
   int tread[$];
   int bad_count = 0, checks_done = 0, cyc = 0, n, m, i;

   sarc_conv_ctrl #(.CONV_DIV(DIV), .FIFO_DEPTH(SARC_FIFO_DEPTH)) sarc_conv_ctrl_inst (
      .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .pwr_on_in(pwr_on_in), .start_in(start_in),
      .frame_start_in(frame_start_in), .single_conversion_select_in(single_sel),
      .diff_sel_in(diff_sel), .comp_in(comp_in), .rd_ready_in(rd_ready), .dac_code_out(dac_code),
      .sample_out(sample), .diff_mode_out(diff_mode), .ready_out(ready), .busy_out(busy),
      .done_flag_out(done_flag), .frame_end_out(frame_end), .result_out(result));
   sarc_reader sarc_reader_inst (.clk_sys_in(clk_sys_in), .frame_end_in(frame_end),
      .stall_in(stall), .rd_ready_out(rd_ready));

   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cyc++;
      if (rstn_in && frame_end && rd_ready) begin
         got.push_back(result);
         tread.push_back(cyc);
      end
   end
   // comparator: one when the held input is at or above the trial code
   always @(negedge clk_sys_in) begin
      comp_in <= (target >= dac_code);
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [11:0] sar_expect(input logic [11:0] t);
      logic [11:0] code;
      code = '0;
      for (int b = 11; b >= 0; b--) begin
         if (t >= (code | (12'h001 << b))) begin
            code = code | (12'h001 << b);
         end
      end
      return code;
   endfunction
   task automatic check(input logic [31:0] a, input logic [31:0] e);
      checks_done++;
      if (a !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic bound(input int k, input int lim);
      if (k >= lim) begin
         bad_count++;
         tally_and_finish();
      end
   endtask
   // a start pulse during the wait must be dropped
   task automatic power_up;
      int k;
      logic seen;
      k = 0;
      seen = 1'b0;
      @(negedge clk_sys_in);
      pwr_on_in = 1'b1;
      start_in = 1'b1;
      while (!ready && k < 1100) begin
         @(negedge clk_sys_in);
         // one more start pulse well inside the wait
         start_in = (k == 500);
         seen = seen | busy;
         k++;
      end
      bound(k, 1100);
      check(k >= 1000 && k <= 1002, 1);
      check(seen, 0);
   endtask
   task automatic convert(input logic use_fs);
      int k, s;
      logic d;
      k = 0;
      d = 1'($urandom);
      @(negedge clk_sys_in);
      diff_sel = d;
      if (use_fs) begin
         frame_start_in = 1'b1;
      end else begin
         start_in = 1'b1;
      end
      while (!busy && k < 10) begin
         @(negedge clk_sys_in);
         start_in = 1'b0;
         k++;
      end
      bound(k, 10);
      check(sample, 1);
      s = 1;
      k = 0;
      while (!frame_end && k < 300) begin
         @(negedge clk_sys_in);
         start_in = (k == 20);
         if (sample) begin
            s++;
         end
         k++;
      end
      bound(k, 300);
      check(k, CONV);
      check(s, SARC_SAMPLE_STEPS * DIV);
      check(diff_mode, d);
      check(done_flag, 1);
      repeat (3) @(negedge clk_sys_in);
      frame_start_in = 1'b0;
      check({frame_end, done_flag}, 0);
      check(got.size(), 1);
      if (got.size() > 0) begin
         check(got.pop_front(), sar_expect(target));
      end
      repeat (2 * CONV) @(negedge clk_sys_in);
      check({got.size() != 0, busy}, 0);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h9ff5));
      repeat (4) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      rstn_in = 1'b1;
      check({ready, busy, done_flag, frame_end}, 0);
      power_up();
      for (i = 0; i < 10; i++) begin
         target = (i < 4) ? corner[i] : 12'($urandom);
         convert(i[0]);
      end
      // continuous with the reader stalled: the fifo fills and conversion holds off
      stall = 1'b1;
      target = 12'($urandom);
      single_sel = 1'b0;
      n = 0;
      m = 0;
      while (m < CONV + 4 && n < 30 * CONV) begin
         @(negedge clk_sys_in);
         m = busy ? 0 : m + 1;
         n++;
      end
      bound(n, 30 * CONV);
      check(frame_end, 1);
      single_sel = 1'b1;
      stall = 1'b0;
      n = 0;
      while (frame_end && n < 100) begin
         @(negedge clk_sys_in);
         n++;
      end
      bound(n, 100);
      check(got.size(), SARC_FIFO_DEPTH);
      foreach (got[j]) check(got[j], sar_expect(target));
      got.delete();
      tread.delete();
      single_sel = 1'b0;
      n = 0;
      while (got.size() < 3 && n < 5 * CONV) begin
         @(negedge clk_sys_in);
         n++;
      end
      bound(n, 5 * CONV);
      single_sel = 1'b1;
      check(tread[2] - tread[1], CONV);
      repeat (2 * CONV) @(negedge clk_sys_in);
      pwr_on_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      check({ready, busy}, 0);
      power_up();
      tally_and_finish();
   end
endmodule
